// file: hw/charge_cycle_supervisor.sv
// charge cycle supervisor: termination, top-off, thermal derating, timers, balancing
// Contract
// - end the cycle when above recharge level and current below termination level
// - on termination raise the indicator, report code 110 (101 when top-off is selected) and pulse the interrupt
// - no termination during input current, input voltage or thermal regulation
// - termination enable cleared before termination inhibits termination
// - top-off timer off by default, follows safety timer suspend and half rate
// - top-off running reports 101; on expiry code 110 and interrupt pulse
// - top-off timer cleared by re-enable, termination rise and register reset
// - top-off length sampled at termination; later writes wait for recharge
// - interrupt on top-off entry and expiry; one mask hides charge events
// - start only inside thermistor window; suspend outside it
// - warm range voltage is normal, 4.0 V, 4.15 V or suspend
// - warm range current is 100% or 40% by one bit
// - cool range current is 100%, 40%, 20% or suspend
// - warm or cool range always disables termination
// - safety timer length programmable; expiry sets fault bit and interrupt
// - safety timer half rate during regulation or active balancing
// - half rate enable cleared stops slowdown without touching the count
// - safety timer frozen during charge faults and supplement mode
// - safety timer reset on restart, recharge and pre/fast transitions
// - fixed 2 h pre-charge timer under the same timer rules
// - threshold defaults: measure pause on, prequal 1111 off, start 0100
// - timing defaults: offset 40 mV, 2 min intervals, 1 s settle
// - auto balance enable at mode bit 6, on by default
`timescale 1ns/100ps
module charge_cycle_supervisor #(
   parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register access
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   output logic [7:0] reg_rdata_o,
   // control bits from the host
   input wire logic charge_enable_bit_i,
   input wire logic term_enable_i,
   input wire logic timer_enable_i,
   input wire logic half_rate_timer_enable_i,
   input wire logic [1:0] fast_charge_timer_length_i,
   input wire logic [1:0] topoff_select_i,
   input wire logic [1:0] warm_voltage_select_i,
   input wire logic warm_current_select_i,
   input wire logic [1:0] cool_current_select_i,
   input wire logic charge_event_mask_i,
   input wire logic reg_reset_i,
   // pins and analog comparators
   input wire logic charge_disable_pin_i,
   input wire logic bat_above_recharge_i,
   input wire logic current_below_term_i,
   input wire logic bat_below_lowv_i,
   input wire logic input_current_regulating_i,
   input wire logic input_voltage_regulating_i,
   input wire logic thermal_regulating_i,
   input wire logic thermistor_in_range_i,
   input wire logic thermistor_warm_i,
   input wire logic thermistor_cool_i,
   input wire logic charge_fault_i,
   input wire logic supplement_mode_i,
   // cell difference from the measurement path
   input wire logic [9:0] cell_diff_mv_i,
   // status and control outputs
   output logic [2:0] charge_phase_code_o,
   output logic charge_indicator_o,
   output logic interrupt_pulse_o,
   output logic safety_timer_expired_o,
   output logic charging_o,
   output logic [1:0] voltage_select_o,
   output logic [6:0] current_percent_o,
   output logic balance_active_o
);
   // pin synchronisers
   logic [ccs_pkg::NPIN-1:0] pin_raw, pin_m_q, pin_s_q;
   assign pin_raw = {supplement_mode_i, charge_fault_i, thermistor_cool_i, thermistor_warm_i,
      thermistor_in_range_i, thermal_regulating_i, input_voltage_regulating_i,
      input_current_regulating_i, bat_below_lowv_i, current_below_term_i,
      bat_above_recharge_i, charge_disable_pin_i};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_m_q <= '0;
         pin_s_q <= '0;
      end else begin
         pin_m_q <= pin_raw;
         pin_s_q <= pin_m_q;
      end
   end
   logic ts_ok, warm, cool, in_reg, freeze;
   assign ts_ok = pin_s_q[ccs_pkg::P_TSOK];
   assign warm = pin_s_q[ccs_pkg::P_WARM];
   assign cool = pin_s_q[ccs_pkg::P_COOL];
   assign in_reg = pin_s_q[ccs_pkg::P_IINDPM] | pin_s_q[ccs_pkg::P_VINDPM] |
      pin_s_q[ccs_pkg::P_TREG];
   // time base: full and half rate tick enables
   logic [ccs_pkg::DIV_W-1:0] div_d, div_q;
   logic half_d, half_q, tick, tick_half;
   always_comb begin
      tick = (div_q == ccs_pkg::DIV_W'(TICK_CYCLES - 1));
      div_d = tick ? '0 : div_q + 1'b1;
      half_d = tick ? !half_q : half_q;
      tick_half = tick && half_q;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= '0;
         half_q <= 1'b0;
      end else begin
         div_q <= div_d;
         half_q <= half_d;
      end
   end
   // balance registers
   logic [7:0] bal_tim_d, bal_tim_q, bal_thr_d, bal_thr_q, bal_mode_d, bal_mode_q;
   logic [7:0] rdata_d, rdata_q;
   logic bal_act_d, bal_act_q;
   always_comb begin
      bal_tim_d = bal_tim_q;
      bal_thr_d = bal_thr_q;
      bal_mode_d = bal_mode_q;
      if (reg_reset_i) begin
         bal_tim_d = ccs_pkg::RST_BAL_TIMING;
         bal_thr_d = ccs_pkg::RST_BAL_THRESH;
         bal_mode_d = ccs_pkg::RST_BAL_MODE;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            ccs_pkg::ADDR_BAL_TIMING: bal_tim_d = reg_wdata_i;
            ccs_pkg::ADDR_BAL_THRESH: bal_thr_d = reg_wdata_i;
            ccs_pkg::ADDR_BAL_MODE: bal_mode_d = reg_wdata_i & ~8'h01;
            default: bal_mode_d = bal_mode_q;
         endcase
      end
      unique case (reg_addr_i)
         ccs_pkg::ADDR_BAL_TIMING: rdata_d = bal_tim_q;
         ccs_pkg::ADDR_BAL_THRESH: rdata_d = bal_thr_q;
         ccs_pkg::ADDR_BAL_MODE: rdata_d = bal_mode_q | {7'h00, bal_act_q};
         default: rdata_d = 8'h00;
      endcase
   end
   // balance hysteresis on the cell difference
   logic [9:0] start_mv, off_mv, stop_mv;
   always_comb begin
      start_mv = 10'(bal_thr_q[ccs_pkg::BT_START_LSB +: 4] * ccs_pkg::START_STEP_MV);
      off_mv = 10'(bal_tim_q[ccs_pkg::TM_OFFSET_LSB +: 3] * ccs_pkg::OFFSET_STEP_MV);
      stop_mv = (start_mv > off_mv) ? start_mv - off_mv : 10'h000;
      bal_act_d = bal_act_q;
      if (!bal_mode_q[ccs_pkg::BM_AUTO_BIT]) bal_act_d = 1'b0;
      else if (cell_diff_mv_i > start_mv) bal_act_d = 1'b1;
      else if (cell_diff_mv_i < stop_mv) bal_act_d = 1'b0;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bal_tim_q <= ccs_pkg::RST_BAL_TIMING;
         bal_thr_q <= ccs_pkg::RST_BAL_THRESH;
         bal_mode_q <= ccs_pkg::RST_BAL_MODE;
         rdata_q <= 8'h00;
         bal_act_q <= 1'b0;
      end else begin
         bal_tim_q <= bal_tim_d;
         bal_thr_q <= bal_thr_d;
         bal_mode_q <= bal_mode_d;
         rdata_q <= rdata_d;
         bal_act_q <= bal_act_d;
      end
   end
   ccs_timer_if safe_if ();
   ccs_timer_if top_if ();
   ccs_timer u_safe (.clk_i(clk_i), .rst_i(rst_i), .t(safe_if));
   ccs_timer u_top (.clk_i(clk_i), .rst_i(rst_i), .t(top_if));
   // charge cycle
   ccs_pkg::ccs_state_t state_d, state_q;
   logic en, en_q, en_rise, temp_susp, suspend, term_ok, term_evt, safe_evt, slow, step;
   logic fault_d, fault_q, int_d, int_q, ind_d, ind_q;
   logic [1:0] topsel_d, topsel_q, vsel_d, vsel_q;
   logic [2:0] code_d, code_q;
   logic [6:0] pct_d, pct_q;
   always_comb begin
      en = charge_enable_bit_i && !pin_s_q[ccs_pkg::P_CD];
      en_rise = en && !en_q;
      temp_susp = !ts_ok || (warm && warm_voltage_select_i == ccs_pkg::VSEL_SUSPEND) ||
         (cool && cool_current_select_i == ccs_pkg::CSEL_SUSPEND);
      freeze = pin_s_q[ccs_pkg::P_FAULT] || pin_s_q[ccs_pkg::P_SUPP] || temp_susp;
      suspend = freeze || fault_q;
      term_ok = pin_s_q[ccs_pkg::P_RECHG] && pin_s_q[ccs_pkg::P_TERMI] && !in_reg &&
         term_enable_i && !warm && !cool && !suspend;
      state_d = state_q;
      if (!en) begin
         state_d = ccs_pkg::CCS_IDLE;
      end else begin
         unique case (state_q)
            ccs_pkg::CCS_IDLE: begin
               if (ts_ok && !fault_q) state_d = pin_s_q[ccs_pkg::P_LOWV] ? ccs_pkg::CCS_PRE :
                  ccs_pkg::CCS_FAST;
            end
            ccs_pkg::CCS_PRE: if (!pin_s_q[ccs_pkg::P_LOWV]) state_d = ccs_pkg::CCS_FAST;
            ccs_pkg::CCS_FAST: begin
               if (pin_s_q[ccs_pkg::P_LOWV]) begin
                  state_d = ccs_pkg::CCS_PRE;
               end else if (term_ok) begin
                  state_d = (topoff_select_i != 2'h0) ? ccs_pkg::CCS_TOPOFF : ccs_pkg::CCS_DONE;
               end
            end
            ccs_pkg::CCS_TOPOFF: if (top_if.expired) state_d = ccs_pkg::CCS_DONE;
            ccs_pkg::CCS_DONE: begin
               if (!pin_s_q[ccs_pkg::P_RECHG]) state_d = pin_s_q[ccs_pkg::P_LOWV] ?
                  ccs_pkg::CCS_PRE : ccs_pkg::CCS_FAST;
            end
            default: state_d = ccs_pkg::CCS_IDLE;
         endcase
      end
      term_evt = (state_q == ccs_pkg::CCS_FAST) &&
         (state_d == ccs_pkg::CCS_TOPOFF || state_d == ccs_pkg::CCS_DONE);
      topsel_d = topsel_q;
      if (reg_reset_i) topsel_d = 2'h0;
      else if (term_evt) topsel_d = topoff_select_i;
      slow = half_rate_timer_enable_i && (in_reg || bal_act_q);
      step = slow ? tick_half : tick;
      // safety timer: clears on every entry into pre or fast charge
      safe_if.clear = !en || ((state_d == ccs_pkg::CCS_PRE || state_d == ccs_pkg::CCS_FAST) &&
         state_d != state_q);
      safe_if.run = timer_enable_i && !freeze &&
         (state_q == ccs_pkg::CCS_PRE || state_q == ccs_pkg::CCS_FAST);
      safe_if.step = step;
      unique case (fast_charge_timer_length_i)
         2'h0: safe_if.limit = ccs_pkg::FAST_T0;
         2'h1: safe_if.limit = ccs_pkg::FAST_T1;
         2'h2: safe_if.limit = ccs_pkg::FAST_T2;
         2'h3: safe_if.limit = ccs_pkg::FAST_T3;
      endcase
      if (state_q == ccs_pkg::CCS_PRE) safe_if.limit = ccs_pkg::PRECHG_TICKS;
      safe_evt = safe_if.expired && timer_enable_i && !fault_q;
      fault_d = safe_evt || (fault_q && !en_rise);
      top_if.clear = reg_reset_i || en_rise || term_evt;
      top_if.run = (state_q == ccs_pkg::CCS_TOPOFF) && !freeze;
      top_if.step = step;
      unique case (term_evt ? topoff_select_i : topsel_q)
         2'h1: top_if.limit = ccs_pkg::TOPOFF_T1;
         2'h2: top_if.limit = ccs_pkg::TOPOFF_T2;
         2'h3: top_if.limit = ccs_pkg::TOPOFF_T3;
         2'h0: top_if.limit = '0;
      endcase
      unique case (state_d)
         ccs_pkg::CCS_IDLE: code_d = ccs_pkg::PH_IDLE;
         ccs_pkg::CCS_PRE: code_d = ccs_pkg::PH_PRE;
         ccs_pkg::CCS_FAST: code_d = ccs_pkg::PH_FAST;
         ccs_pkg::CCS_TOPOFF: code_d = ccs_pkg::PH_TOPOFF;
         ccs_pkg::CCS_DONE: code_d = ccs_pkg::PH_DONE;
         default: code_d = ccs_pkg::PH_IDLE;
      endcase
      ind_d = !en || state_d == ccs_pkg::CCS_TOPOFF || state_d == ccs_pkg::CCS_DONE;
      int_d = ((code_d != code_q) && !charge_event_mask_i) || safe_evt;
      vsel_d = warm ? warm_voltage_select_i : ccs_pkg::VSEL_NORMAL;
      pct_d = ccs_pkg::PCT_100;
      if (warm && warm_current_select_i) pct_d = ccs_pkg::PCT_40;
      if (cool) begin
         unique case (cool_current_select_i)
            ccs_pkg::CSEL_100: pct_d = ccs_pkg::PCT_100;
            ccs_pkg::CSEL_40: pct_d = ccs_pkg::PCT_40;
            ccs_pkg::CSEL_20: pct_d = ccs_pkg::PCT_20;
            ccs_pkg::CSEL_SUSPEND: pct_d = ccs_pkg::PCT_0;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ccs_pkg::CCS_IDLE;
         en_q <= 1'b0;
         fault_q <= 1'b0;
         topsel_q <= 2'h0;
         code_q <= ccs_pkg::PH_IDLE;
         ind_q <= 1'b1;
         int_q <= 1'b0;
         vsel_q <= ccs_pkg::VSEL_NORMAL;
         pct_q <= ccs_pkg::PCT_100;
      end else begin
         state_q <= state_d;
         en_q <= en;
         fault_q <= fault_d;
         topsel_q <= topsel_d;
         code_q <= code_d;
         ind_q <= ind_d;
         int_q <= int_d;
         vsel_q <= vsel_d;
         pct_q <= pct_d;
      end
   end
   assign reg_rdata_o = rdata_q;
   assign charge_phase_code_o = code_q;
   assign charge_indicator_o = ind_q;
   assign interrupt_pulse_o = int_q;
   assign safety_timer_expired_o = fault_q;
   assign charging_o = (state_q == ccs_pkg::CCS_PRE || state_q == ccs_pkg::CCS_FAST ||
      state_q == ccs_pkg::CCS_TOPOFF) && !suspend;
   assign voltage_select_o = vsel_q;
   assign current_percent_o = pct_q;
   assign balance_active_o = bal_act_q;
   a_term_done_code: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_FAST && state_d == ccs_pkg::CCS_DONE |=>
      charge_phase_code_o == ccs_pkg::PH_DONE && charge_indicator_o) else $error("bad term");
   a_no_term_regulating: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_FAST && in_reg |=> state_q != ccs_pkg::CCS_DONE &&
      state_q != ccs_pkg::CCS_TOPOFF) else $error("term in regulation");
   a_term_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_FAST && !term_enable_i |=> state_q != ccs_pkg::CCS_DONE &&
      state_q != ccs_pkg::CCS_TOPOFF) else $error("term while inhibited");
   a_topoff_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_TOPOFF && top_if.expired && en |=>
      charge_phase_code_o == ccs_pkg::PH_DONE) else $error("topoff expiry");
   a_mask_hides_int: assert property (@(posedge clk_i) disable iff (rst_i)
      charge_event_mask_i && !safe_evt |=> !interrupt_pulse_o) else $error("masked int");
   a_no_start_cold: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_IDLE && !ts_ok |=> state_q == ccs_pkg::CCS_IDLE)
      else $error("start outside window");
   a_warm_current: assert property (@(posedge clk_i) disable iff (rst_i)
      warm && !cool && warm_current_select_i |=> current_percent_o == ccs_pkg::PCT_40)
      else $error("warm derate");
   a_jeita_no_term: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_FAST && (warm || cool) |=> state_q != ccs_pkg::CCS_DONE)
      else $error("term in warm or cool");
   a_safety_fault: assert property (@(posedge clk_i) disable iff (rst_i)
      safe_evt |=> safety_timer_expired_o && interrupt_pulse_o) else $error("no fault");
   a_phase_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_PRE && state_d == ccs_pkg::CCS_FAST |=>
      safe_if.count == '0) else $error("timer kept across phase");
   a_balance_exit: assert property (@(posedge clk_i) disable iff (rst_i)
      bal_mode_q[ccs_pkg::BM_AUTO_BIT] && cell_diff_mv_i < stop_mv && cell_diff_mv_i <= start_mv
      |=> !balance_active_o) else $error("balance kept");
   c_topoff_entry: cover property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_FAST ##1 state_q == ccs_pkg::CCS_TOPOFF);
   c_topoff_done: cover property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_TOPOFF ##1 state_q == ccs_pkg::CCS_DONE);
   c_safety_expiry: cover property (@(posedge clk_i) disable iff (rst_i) safe_evt);
   c_recharge: cover property (@(posedge clk_i) disable iff (rst_i)
      state_q == ccs_pkg::CCS_DONE ##1 state_q == ccs_pkg::CCS_FAST);
endmodule

// file: inc/ccs_pkg.sv
// constants and types shared by the charge cycle supervisor
package ccs_pkg;
   // register offsets
   localparam logic [7:0] ADDR_BAL_TIMING = 8'h28;
   localparam logic [7:0] ADDR_BAL_THRESH = 8'h29;
   localparam logic [7:0] ADDR_BAL_MODE = 8'h2A;
   // reset values
   localparam logic [7:0] RST_BAL_TIMING = 8'h2A;
   localparam logic [7:0] RST_BAL_THRESH = 8'hF4;
   localparam logic [7:0] RST_BAL_MODE = 8'hC0;
   // field positions
   localparam int BM_MEAS_OFF_BIT = 7;
   localparam int BM_AUTO_BIT = 6;
   localparam int BM_ACTIVE_BIT = 0;
   localparam int BT_START_LSB = 0;
   localparam int BT_PREQ_LSB = 4;
   localparam int TM_OFFSET_LSB = 5;
   // balance thresholds in mV per step
   localparam int DIFF_W = 10;
   localparam logic [9:0] START_STEP_MV = 10'h014;
   localparam logic [9:0] OFFSET_STEP_MV = 10'h028;
   // time base
   localparam int CLK_HZ = 250000000;
   localparam int TICK_S = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_S;
   localparam int DIV_W = 28;
   // timer lengths in ticks (seconds)
   localparam int TMR_W = 17;
   localparam int HOUR_S = 3600;
   localparam logic [16:0] PRECHG_TICKS = 17'(2 * HOUR_S);
   localparam logic [16:0] FAST_T0 = 17'(5 * HOUR_S);
   localparam logic [16:0] FAST_T1 = 17'(8 * HOUR_S);
   localparam logic [16:0] FAST_T2 = 17'(12 * HOUR_S);
   localparam logic [16:0] FAST_T3 = 17'(20 * HOUR_S);
   localparam logic [16:0] TOPOFF_T1 = 17'(15 * 60);
   localparam logic [16:0] TOPOFF_T2 = 17'(30 * 60);
   localparam logic [16:0] TOPOFF_T3 = 17'(45 * 60);
   // charge phase codes
   localparam logic [2:0] PH_IDLE = 3'h0;
   localparam logic [2:0] PH_PRE = 3'h2;
   localparam logic [2:0] PH_FAST = 3'h3;
   localparam logic [2:0] PH_TOPOFF = 3'h5;
   localparam logic [2:0] PH_DONE = 3'h6;
   // derating selections
   localparam logic [1:0] VSEL_NORMAL = 2'h0;
   localparam logic [1:0] VSEL_4V00 = 2'h1;
   localparam logic [1:0] VSEL_4V15 = 2'h2;
   localparam logic [1:0] VSEL_SUSPEND = 2'h3;
   localparam logic [1:0] CSEL_100 = 2'h0;
   localparam logic [1:0] CSEL_40 = 2'h1;
   localparam logic [1:0] CSEL_20 = 2'h2;
   localparam logic [1:0] CSEL_SUSPEND = 2'h3;
   localparam logic [6:0] PCT_100 = 7'h64;
   localparam logic [6:0] PCT_40 = 7'h28;
   localparam logic [6:0] PCT_20 = 7'h14;
   localparam logic [6:0] PCT_0 = 7'h00;
   // synchronised pin vector positions
   localparam int NPIN = 12;
   localparam int P_CD = 0;
   localparam int P_RECHG = 1;
   localparam int P_TERMI = 2;
   localparam int P_LOWV = 3;
   localparam int P_IINDPM = 4;
   localparam int P_VINDPM = 5;
   localparam int P_TREG = 6;
   localparam int P_TSOK = 7;
   localparam int P_WARM = 8;
   localparam int P_COOL = 9;
   localparam int P_FAULT = 10;
   localparam int P_SUPP = 11;
   // charge cycle states, gray along idle-pre-fast-topoff-done
   typedef enum logic [2:0] {
      CCS_IDLE = 3'b000,
      CCS_PRE = 3'b001,
      CCS_FAST = 3'b011,
      CCS_TOPOFF = 3'b010,
      CCS_DONE = 3'b110
   } ccs_state_t;
endpackage

// file: inc/ccs_timer_if.sv
// control and status of one charge timer
`timescale 1ns/100ps
interface ccs_timer_if;
   logic clear;
   logic run;
   logic step;
   logic [16:0] limit;
   logic [16:0] count;
   logic expired;
   modport tmr (input clear, input run, input step, input limit, output count, output expired);
   modport ctl (output clear, output run, output step, output limit, input count, input expired);
endinterface

// file: hw/ccs_timer.sv
// charge timer with clear, hold and stepped count
`timescale 1ns/100ps
module ccs_timer (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   ccs_timer_if.tmr t
);
   logic [16:0] count_d, count_q;
   logic expired_d, expired_q;

   always_comb begin
      count_d = count_q;
      if (t.clear) begin
         count_d = '0;
      end else if (t.run && t.step && !expired_q) begin
         count_d = count_q + 17'h00001;
      end
      expired_d = !t.clear && (t.limit != '0) && (count_d >= t.limit);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= '0;
         expired_q <= 1'b0;
      end else begin
         count_q <= count_d;
         expired_q <= expired_d;
      end
   end

   assign t.count = count_q;
   assign t.expired = expired_q;

   a_timer_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      t.clear |=> (count_q == '0) && !expired_q) else $error("timer not cleared");
   a_timer_hold_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
      !t.run && !t.clear |=> $stable(count_q)) else $error("timer moved while held");
endmodule

// file: testbench/ccs_pack_model.sv
// battery pack model: comparator levels of a two-cell pack
`timescale 1ns/100ps
module ccs_pack_model (
   // pack state
   input wire logic full_i,
   // comparator levels
   output logic above_rechg_o,
   output logic below_term_o
);
   // a full pack sits above recharge with tapered current
   assign above_rechg_o = full_i;
   assign below_term_o = full_i;
endmodule

// file: testbench/charge_cycle_supervisor_tb_top.sv
// self-checking testbench of the charge cycle supervisor
`timescale 1ns/100ps
module charge_cycle_supervisor_tb_top;
   logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_reset_i = 0, full = 0;
   logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, d;
   logic charge_enable_bit_i = 0, term_enable_i = 1, timer_enable_i = 1;
   logic half_rate_timer_enable_i = 1, warm_current_select_i = 0, charge_event_mask_i = 0;
   logic [1:0] fast_charge_timer_length_i = 0, topoff_select_i = 0;
   logic [1:0] warm_voltage_select_i = 0, cool_current_select_i = 0, voltage_select_o;
   logic charge_disable_pin_i = 0, bat_above_recharge_i, current_below_term_i;
   logic bat_below_lowv_i = 0, input_current_regulating_i = 0, input_voltage_regulating_i = 0;
   logic thermal_regulating_i = 0, thermistor_in_range_i = 1, thermistor_warm_i = 0;
   logic thermistor_cool_i = 0, charge_fault_i = 0, supplement_mode_i = 0;
   logic [9:0] cell_diff_mv_i = 0;
   logic [2:0] charge_phase_code_o;
   logic charge_indicator_o, interrupt_pulse_o, safety_timer_expired_o, charging_o;
   logic balance_active_o;
   logic [6:0] current_percent_o;
   logic [7:0] pct [4] = '{8'h64, 8'h28, 8'h14, 8'h00};
   int fails = 0, checked = 0, ints = 0, seed = 32'h9f2f, i0;
   int mdl [3] = '{32'h2A, 32'hF4, 32'hC0};
   charge_cycle_supervisor #(.TICK_CYCLES(4)) dut_u (.*);
   ccs_pack_model pack_u (.full_i(full), .above_rechg_o(bat_above_recharge_i),
      .below_term_o(current_below_term_i));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      if (interrupt_pulse_o === 1'b1) ints++;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic settle();
      repeat (8) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1;
      @(posedge clk_i);
      reg_wr_i <= 0;
      if (a >= 8'h28 && a <= 8'h2A) mdl[a - 8'h28] = int'((a == 8'h2A) ? (v & 8'hFE) : v);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      reg_addr_i <= a;
      settle();
      chk(reg_rdata_o, (a >= 8'h28 && a <= 8'h2A) ? 8'(mdl[a - 8'h28]) : 8'h00);
   endtask
   task automatic give_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      fails++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      rd(8'h28);
      rd(8'h29);
      rd(8'h2A);
      rd(8'h31);
      d = 8'($random(seed));
      wr(8'h29, d);
      rd(8'h29);
      @(posedge clk_i) reg_reset_i <= 1;
      @(posedge clk_i) reg_reset_i <= 0;
      mdl = '{32'h2A, 32'hF4, 32'hC0};
      rd(8'h29);
      chk(8'(charge_indicator_o), 8'h01);
      @(posedge clk_i) charge_enable_bit_i <= 1;
      settle();
      chk(8'(charge_phase_code_o), 8'h03);
      @(posedge clk_i) thermistor_in_range_i <= 0;
      settle();
      chk(8'(charging_o), 8'h00);
      @(posedge clk_i) thermistor_in_range_i <= 1;
      @(posedge clk_i) thermistor_warm_i <= 1;
      for (int v = 0; v < 4; v++) begin
         @(posedge clk_i) warm_voltage_select_i <= 2'(v);
         warm_current_select_i <= v[0];
         settle();
         chk(8'(voltage_select_o), 8'(v));
         if (v < 3) chk(8'(current_percent_o), pct[v & 1]);
      end
      @(posedge clk_i) warm_voltage_select_i <= 0;
      full <= 1;
      settle();
      chk(8'(charge_phase_code_o), 8'h03);
      @(posedge clk_i) thermistor_warm_i <= 0;
      thermistor_cool_i <= 1;
      full <= 0;
      for (int v = 0; v < 4; v++) begin
         @(posedge clk_i) cool_current_select_i <= 2'(v);
         settle();
         chk(8'(current_percent_o), pct[v]);
      end
      @(posedge clk_i) thermistor_cool_i <= 0;
      term_enable_i <= 0;
      full <= 1;
      settle();
      chk(8'(charge_phase_code_o), 8'h03);
      @(posedge clk_i) full <= 0;
      term_enable_i <= 1;
      input_current_regulating_i <= 1;
      settle();
      @(posedge clk_i) full <= 1;
      settle();
      chk(8'(charge_phase_code_o), 8'h03);
      i0 = ints;
      @(posedge clk_i) input_current_regulating_i <= 0;
      settle();
      chk(8'(charge_phase_code_o), 8'h06);
      chk({charge_indicator_o, 7'(ints - i0)}, 8'h81);
      @(posedge clk_i) full <= 0;
      topoff_select_i <= 1;
      settle();
      @(posedge clk_i) full <= 1;
      settle();
      chk(8'(charge_phase_code_o), 8'h05);
      i0 = ints;
      repeat (3700) @(posedge clk_i);
      #1;
      chk(8'(charge_phase_code_o), 8'h06);
      chk(8'(ints - i0), 8'h01);
      @(posedge clk_i) cell_diff_mv_i <= 10'(81 + $unsigned($random(seed)) % 200);
      settle();
      chk(8'(balance_active_o), 8'h01);
      @(posedge clk_i) cell_diff_mv_i <= 10'h014;
      settle();
      chk(8'(balance_active_o), 8'h00);
      @(posedge clk_i) charge_event_mask_i <= 1;
      bat_below_lowv_i <= 1;
      full <= 0;
      i0 = ints;
      settle();
      chk(8'(charge_phase_code_o), 8'h02);
      repeat (28770) @(posedge clk_i);
      #1;
      chk({charging_o, 6'h00, safety_timer_expired_o}, 8'h80);
      repeat (40) @(posedge clk_i);
      #1;
      chk({charging_o, 6'h00, safety_timer_expired_o}, 8'h01);
      chk(8'(ints - i0), 8'h01);
      @(posedge clk_i) bat_below_lowv_i <= 0;
      settle();
      chk({5'h00, charge_phase_code_o}, 8'h03);
      give_verdict();
   end
endmodule
